// ### hdl/ltl_pkg.sv
/*
  constants, register map and types for the four-slice logic tile.
  assumes one clock at 250 MHz and an ahb-lite master on the config bus.
*/
package ltl_pkg;
  localparam int NSL = 4;
  localparam int CFG_W = 12;
  // byte offsets of the register words
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_LUT0 = 8'h10;
  localparam logic [7:0] REG_CFG0 = 8'h20;
  localparam logic [23:0] HI_ZERO = 24'h000000;
  // control bits
  localparam int C_USER = 0;
  localparam int C_RAM = 1;
  localparam int C_PDP = 2;
  localparam int CTRL_W = 3;
  // per-slice configuration fields
  localparam int CF_LUT5 = 0;
  localparam int CF_SRC0 = 1;
  localparam int CF_SRC1 = 2;
  localparam int CF_ASYNC = 3;
  localparam int CF_NEG = 4;
  localparam int CF_INIT0 = 5;
  localparam int CF_INIT1 = 6;
  localparam int CF_RIP = 7;
  localparam int CF_OP = 8;
  localparam int OP_W = 4;
  typedef enum logic [OP_W-1:0] {
    OP_ADD, OP_SUB, OP_ADDSUB, OP_UP, OP_DN, OP_UDCLR, OP_UDLD,
    OP_CMP, OP_UDGE, OP_UDLE, OP_DIV, OP_MUL1, OP_MUL2
  } ltl_op_e;
  typedef struct packed {
    logic [NSL-1:0][1:0][15:0] lut;
    logic [NSL-1:0][CFG_W-1:0] cfg;
    logic [CTRL_W-1:0] ctrl;
    logic [7:0] q;
    logic [1:0] clk_prev;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic ready;
    logic resp;
  } ltl_state_s;
endpackage

// ### hdl/ltl_tile.sv
/*
  four-slice logic tile: tables, flops, ripple arithmetic, distributed
  memory and rom, with an ahb-lite slave for configuration.
  assumes every input is synchronous to ref_clk_in; slice clocks are
  sampled and their edges detected, so they must be well below 125 MHz.
*/
`timescale 1ns/1ps
`default_nettype none
module ltl_tile (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic clk_en_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [15:0] first_table_inputs_in,
  input wire logic [15:0] second_table_inputs_in,
  input wire logic [7:0] direct_ff_inputs_in,
  input wire logic [3:0] lut5_sel_in,
  input wire logic [1:0] slice_clock_in,
  input wire logic [1:0] clock_enable_in,
  input wire logic [1:0] local_set_reset_in,
  input wire logic carry_in_in,
  output logic [3:0] first_function_out_out,
  output logic [3:0] second_function_out_out,
  output logic [7:0] flop_outputs_out,
  output logic carry_out_out
);
  ltl_pkg::ltl_state_s st_reg, st_next;
  logic [ltl_pkg::NSL:0] cc;
  logic [ltl_pkg::NSL-1:0] f0, f1, edge_s;
  logic [ltl_pkg::NSL-1:0][1:0] tq;
  logic [1:0] rise, fall;
  logic [3:0] waddr, wdata;
  logic ram_on, user_on, we;
  logic [7:0] init_vec;

  // pair edges from the sampled slice clocks
  assign rise = slice_clock_in & ~st_reg.clk_prev;
  assign fall = ~slice_clock_in & st_reg.clk_prev;
  assign ram_on = st_reg.ctrl[ltl_pkg::C_RAM];
  assign user_on = st_reg.ctrl[ltl_pkg::C_USER];
  // slice 2 carries write address, data and enable
  assign waddr = first_table_inputs_in[11:8];
  assign wdata = second_table_inputs_in[11:8];
  assign we = direct_ff_inputs_in[4] & clock_enable_in[1] & edge_s[2];
  assign cc[0] = carry_in_in;
  assign carry_out_out = cc[ltl_pkg::NSL];
  // two table results, two flops and carry per slice
  assign first_function_out_out = f0;
  assign second_function_out_out = f1;
  assign flop_outputs_out = st_reg.q;
  assign hrdata_out = st_reg.rdata;
  assign hreadyout_out = st_reg.ready;
  assign hresp_out = st_reg.resp;

  // one datapath per slice
  genvar s;
  generate
    for (s = 0; s < ltl_pkg::NSL; s++) begin : g_sl
      logic [3:0] i0, i1, r0, r1;
      logic [1:0] a, b, x, y, qq, g, p, sum, sh, rr;
      logic [3:0] ml;
      logic c1, ctl, rip, mem, ctl_sl, lut_f0, ge;
      ltl_pkg::ltl_op_e op;
      // pair clock polarity
      assign edge_s[s] = st_reg.cfg[s][ltl_pkg::CF_NEG] ? fall[s/2] : rise[s/2];
      assign init_vec[2*s] = st_reg.cfg[s][ltl_pkg::CF_INIT0];
      assign init_vec[2*s+1] = st_reg.cfg[s][ltl_pkg::CF_INIT1];
      always_comb begin
        i0 = first_table_inputs_in[4*s +: 4];
        i1 = second_table_inputs_in[4*s +: 4];
        mem = ram_on && (s < 2);
        ctl_sl = ram_on && (s == 2);
        // spr reads at the write address, pseudo_dual_port_memory at its own
        r0 = (mem && !st_reg.ctrl[ltl_pkg::C_PDP]) ? waddr : i0;
        r1 = mem ? r0 : i1;
        a = {i1[0], i0[0]};
        b = {i1[1], i0[1]};
        ctl = i0[2];
        qq = st_reg.q[2*s +: 2];
        op = ltl_pkg::ltl_op_e'(st_reg.cfg[s][ltl_pkg::CF_OP +: ltl_pkg::OP_W]);
        rip = st_reg.cfg[s][ltl_pkg::CF_RIP] && !mem && !ctl_sl;
        x = a;
        y = b;
        sh = {qq[0], direct_ff_inputs_in[2*s]};
        ge = (sh >= b);
        rr = ge ? 2'(sh - b) : sh;
        ml = 4'({2'b00, qq} + 4'(a * b));
        // operand steering for the ripple functions
        unique case (op)
          ltl_pkg::OP_ADD, ltl_pkg::OP_CMP: y = b;
          ltl_pkg::OP_SUB: y = ~b;
          ltl_pkg::OP_ADDSUB: y = ctl ? ~b : b;
          ltl_pkg::OP_UP: begin
            x = qq;
            y = 2'h0;
          end
          ltl_pkg::OP_DN: begin
            x = qq;
            y = 2'h3;
          end
          // direction from ctl
          ltl_pkg::OP_UDCLR, ltl_pkg::OP_UDLD, ltl_pkg::OP_UDGE,
          ltl_pkg::OP_UDLE: begin
            x = qq;
            y = ctl ? 2'h3 : 2'h0;
          end
          default: y = b;
        endcase
        // generate/propagate carry chain
        g = x & y;
        p = x ^ y;
        c1 = g[0] | (p[0] & cc[s]);
        sum = p ^ {c1, cc[s]};
        // 4-input table or 5-input merge on sel
        lut_f0 = st_reg.lut[s][0][r0];
        if (st_reg.cfg[s][ltl_pkg::CF_LUT5] && lut5_sel_in[s] && !mem) begin
          lut_f0 = st_reg.lut[s][1][r1];
        end
        // logic, rom and memory read all use the tables
        f0[s] = lut_f0;
        f1[s] = st_reg.lut[s][1][r1];
        cc[s+1] = cc[s];
        tq[s] = {f1[s], f0[s]};
        if (ctl_sl) begin
          // slice 2 is consumed by memory control
          f0[s] = 1'b0;
          f1[s] = 1'b0;
          tq[s] = qq;
        end else if (rip) begin
          f0[s] = sum[0];
          f1[s] = sum[1];
          cc[s+1] = g[1] | (p[1] & c1);
          tq[s] = sum;
          unique case (op)
            // ge on f0, ne on f1, le on carry
            ltl_pkg::OP_CMP: begin
              f0[s] = (a >= b);
              f1[s] = (a != b);
              cc[s+1] = (a <= b);
              tq[s] = qq;
            end
            ltl_pkg::OP_UDGE: cc[s+1] = (qq >= b);
            ltl_pkg::OP_UDLE: cc[s+1] = (qq <= b);
            ltl_pkg::OP_UDLD: tq[s] = i0[3] ? a : sum;
            // shift one bit per cycle, quotient bit out
            ltl_pkg::OP_DIV: begin
              f0[s] = rr[0];
              f1[s] = rr[1];
              cc[s+1] = ge;
              tq[s] = rr;
            end
            ltl_pkg::OP_MUL1: begin
              ml = 4'({2'b00, qq} + (direct_ff_inputs_in[2*s] ? {2'b00, a}
                                                             : 4'h0));
              f0[s] = ml[0];
              f1[s] = ml[1];
              cc[s+1] = ml[2];
              tq[s] = ml[2:1];
            end
            ltl_pkg::OP_MUL2: begin
              f0[s] = ml[0];
              f1[s] = ml[1];
              cc[s+1] = ml[2];
              tq[s] = ml[3:2];
            end
            default: ;
          endcase
        end
        // table path or direct routing input
        if (st_reg.cfg[s][ltl_pkg::CF_SRC0]) begin
          tq[s][0] = direct_ff_inputs_in[2*s];
        end
        if (st_reg.cfg[s][ltl_pkg::CF_SRC1]) begin
          tq[s][1] = direct_ff_inputs_in[2*s+1];
        end
      end
    end
  endgenerate

  // next state: bus slave, flops, memory writes
  always_comb begin
    logic hit, rd, local_set_reset, clr;
    logic [7:0] ra;
    logic [1:0] ws;
    st_next = st_reg;
    hit = 1'b0;
    rd = 1'b0;
    local_set_reset = 1'b0;
    clr = 1'b0;
    ra = 8'h00;
    ws = 2'h0;
    if (clk_en_in) begin
      st_next.clk_prev = slice_clock_in;
      st_next.ready = 1'b1;
      st_next.resp = 1'b0;
      // data phase of a write; tables and config only before user mode
      if (st_reg.wr_pend) begin
        ra = st_reg.wr_addr;
        ws = 2'(ra[3:2]);
        if (ra == ltl_pkg::REG_CTRL) begin
          st_next.ctrl = hwdata_in[ltl_pkg::CTRL_W-1:0];
        end else if (!user_on && ra[7:4] == ltl_pkg::REG_LUT0[7:4]) begin
          // contents load from config here; memory mode also writes slices 0 and 1
          st_next.lut[ws] = hwdata_in;
        end else if (!user_on && ra[7:4] == ltl_pkg::REG_CFG0[7:4]) begin
          st_next.cfg[ws] = hwdata_in[ltl_pkg::CFG_W-1:0];
        end
      end
      hit = hsel_in && hready_in && htrans_in[1];
      hit = hit && (haddr_in[31:8] == ltl_pkg::HI_ZERO);
      st_next.wr_pend = hit && hwrite_in;
      st_next.wr_addr = {haddr_in[7:2], 2'b00};
      rd = hit && !hwrite_in;
      // read data registered in the address phase, unmapped low reads zero; reads above the low 256 bytes keep the last data
      if (rd) begin
        ra = {haddr_in[7:2], 2'b00};
        ws = 2'(ra[3:2]);
        st_next.rdata = 32'h0000_0000;
        if (ra == ltl_pkg::REG_CTRL) begin
          st_next.rdata[ltl_pkg::CTRL_W-1:0] = st_reg.ctrl;
        end else if (ra == ltl_pkg::REG_STATUS) begin
          st_next.rdata[7:0] = st_reg.q;
          st_next.rdata[11:8] = f0;
          st_next.rdata[15:12] = f1;
        end else if (ra[7:4] == ltl_pkg::REG_LUT0[7:4]) begin
          st_next.rdata = st_reg.lut[ws];
        end else if (ra[7:4] == ltl_pkg::REG_CFG0[7:4]) begin
          st_next.rdata[ltl_pkg::CFG_W-1:0] = st_reg.cfg[ws];
        end
      end
      // slice flops
      for (int i = 0; i < ltl_pkg::NSL; i++) begin
        local_set_reset = local_set_reset_in[i/2];
        clr = st_reg.cfg[i][ltl_pkg::CF_RIP]
              && st_reg.cfg[i][ltl_pkg::CF_OP +: ltl_pkg::OP_W] ==
                 ltl_pkg::OP_UDCLR
              && first_table_inputs_in[4*i+3];
        if (!user_on) begin
          // held at configured init until user mode
          st_next.q[2*i +: 2] = init_vec[2*i +: 2];
        end else if (clr) begin
          st_next.q[2*i +: 2] = 2'h0;
        end else if (local_set_reset && (st_reg.cfg[i][ltl_pkg::CF_ASYNC] || edge_s[i])) begin
          st_next.q[2*i +: 2] = init_vec[2*i +: 2];
        end else if (edge_s[i] && clock_enable_in[i/2]) begin
          st_next.q[2*i +: 2] = tq[i];
        end
      end
      // distributed memory write
      if (user_on && ram_on && we) begin
        st_next.lut[0][0][waddr] = wdata[0];
        st_next.lut[0][1][waddr] = wdata[1];
        st_next.lut[1][0][waddr] = wdata[2];
        st_next.lut[1][1][waddr] = wdata[3];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (sys_rst_in);

  property p_init;
    clk_en_in && !user_on |=> st_reg.q == $past(init_vec);
  endproperty
  a_init: assert property (p_init) else $error("flops not at init");

  property p_hold;
    clk_en_in && user_on && !clock_enable_in[0] && !local_set_reset_in[0]
      && !st_reg.cfg[0][ltl_pkg::CF_RIP] |=> $stable(st_reg.q[1:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("flop moved, ce low");

  property p_async;
    clk_en_in && user_on && local_set_reset_in[0]
      && st_reg.cfg[0][ltl_pkg::CF_ASYNC] && !st_reg.cfg[0][ltl_pkg::CF_RIP]
      |=> st_reg.q[1:0] == $past(init_vec[1:0]);
  endproperty
  a_async: assert property (p_async) else $error("async lsr missed");

  property p_edge;
    clk_en_in && user_on && !edge_s[3] && !local_set_reset_in[1]
      && !st_reg.cfg[3][ltl_pkg::CF_RIP] |=> $stable(st_reg.q[7:6]);
  endproperty
  a_edge: assert property (p_edge) else $error("capture off edge");

  property p_f1;
    !ram_on && !st_reg.cfg[3][ltl_pkg::CF_RIP]
      |-> f1[3] == st_reg.lut[3][1][second_table_inputs_in[15:12]];
  endproperty
  a_f1: assert property (p_f1) else $error("second out not 4-input");

  property p_ramwr;
    clk_en_in && user_on && ram_on && we
      |=> st_reg.lut[1][1][$past(waddr)] == $past(wdata[3]);
  endproperty
  a_ramwr: assert property (p_ramwr) else $error("ram write lost");

  property p_romlock;
    user_on && clk_en_in && st_reg.wr_pend
      && st_reg.wr_addr != ltl_pkg::REG_CTRL |=> $stable(st_reg.cfg);
  endproperty
  a_romlock: assert property (p_romlock) else $error("cfg changed in use");

  property p_carry;
    !ram_on && st_reg.cfg[3][ltl_pkg::CF_RIP]
      && st_reg.cfg[3][ltl_pkg::CF_OP +: ltl_pkg::OP_W] == ltl_pkg::OP_ADD
      |-> carry_out_out == ((g_sl[3].a + g_sl[3].b + 3'(cc[3])) > 3);
  endproperty
  a_carry: assert property (p_carry) else $error("carry out wrong");

  c_user: cover property (!user_on ##1 user_on);
  c_ramwr: cover property (user_on && ram_on && we);
  c_lut5: cover property (lut5_sel_in[0] && st_reg.cfg[0][ltl_pkg::CF_LUT5]);
  c_lsr: cover property (user_on && local_set_reset_in[0]);
endmodule
`default_nettype wire

// ### tb/ltl_nbr.sv
/*
  model of the neighbouring tile at the far end of the carry chain.
  assumes the bench sets the carry that the upstream tile would pass on.
*/
`timescale 1ns/1ps
`default_nettype none
module ltl_nbr (
  input wire logic carry_from_tile_in,
  input wire logic carry_set_in,
  output logic carry_to_tile_out,
  output logic carry_seen_out
);
  // upstream chain output; our carry_out only feeds the next tile
  assign carry_to_tile_out = carry_set_in;
  // what the downstream tile receives on its carry input
  assign carry_seen_out = carry_from_tile_in;
endmodule
`default_nettype wire

// ### tb/ltl_tile_bench.sv
/*
  self-checking bench for the logic tile: config bus, tables, ripple
  arithmetic, flop control. assumes one 250 MHz clock, one bus slave.
*/
`timescale 1ns/1ps
`default_nettype none
module ltl_tile_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [31:0] hrdata;
  logic [1:0] htrans = 2'h0;
  logic [1:0] sclk = 2'h0;
  logic [1:0] ce = 2'h0;
  logic [1:0] local_set_reset = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [15:0] ft = 16'h0;
  logic [15:0] st = 16'h0;
  logic [7:0] dir = 8'h0;
  logic [7:0] q;
  logic [3:0] f0;
  logic [3:0] f1;
  logic cset = 1'b0;
  logic cnb;
  logic [3:0] sel = 4'h0;
  logic hrdy;
  logic hresp;
  logic cin;
  logic cout;
  int mismatches = 0;
  int checks = 0;

  always #2 clk = ~clk;

  ltl_tile u_ltl_tile (
    .ref_clk_in(clk), .sys_rst_in(rst), .clk_en_in(1'b1),
    .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
    .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
    .hresp_out(hresp), .first_table_inputs_in(ft),
    .second_table_inputs_in(st), .direct_ff_inputs_in(dir),
    .lut5_sel_in(sel), .slice_clock_in(sclk), .clock_enable_in(ce),
    .local_set_reset_in(local_set_reset), .carry_in_in(cin),
    .first_function_out_out(f0), .second_function_out_out(f1),
    .flop_outputs_out(q), .carry_out_out(cout)
  );

  ltl_nbr u_ltl_nbr (
    .carry_from_tile_in(cout), .carry_set_in(cset),
    .carry_to_tile_out(cin), .carry_seen_out(cnb)
  );

  task automatic chk(input string n, input logic [31:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // one single transfer; the wait ends only on hready or the watchdog
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string n, input logic [31:0] a, e);
    bus(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask

  // slice clock step; extra edges let the edge detector and flop land
  task automatic slk(input int p, input logic v);
    @(posedge clk);
    sclk[p] <= v;
    repeat (3) @(posedge clk);
  endtask

  task automatic t_regs();
    rdc("ctrl", 32'h0, 32'h0);
    rdc("cfg0", 32'h20, 32'h0);
    wr(32'h40, 32'hFFFFFFFF);
    rdc("unmapped", 32'h40, 32'h0);
    chk("hresp", {31'h0, hresp}, 32'h0);
    wr(32'h14, 32'h80006996);
    wr(32'h18, 32'hFFFF0000);
    wr(32'h20, 32'h00000080);
    wr(32'h28, 32'h00000022);
    wr(32'h0, 32'h00000001);
    wr(32'h28, 32'h00000000);
    rdc("cfg2 locked", 32'h28, 32'h22);
  endtask

  // parity in table 0, and-of-four in table 1 of slice 1
  task automatic t_logic();
    for (int c = 0; c < 16; c++) begin
      @(posedge clk);
      ft[7:4] <= 4'(c);
      st[7:4] <= 4'(c);
      @(posedge clk);
      chk("f0 s1", {31'h0, f0[1]}, {31'h0, ^4'(c)});
      chk("f1 s1", {31'h0, f1[1]}, {31'h0, &4'(c)});
    end
  endtask

  task automatic t_add();
    logic [2:0] s;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      ft[1:0] <= {i[2], i[0]};
      st[1:0] <= {i[3], i[1]};
      cset <= i[4];
      @(posedge clk);
      s = 3'({i[1], i[0]}) + 3'({i[3], i[2]}) + 3'(i[4]);
      chk("sum", {30'h0, f1[0], f0[0]}, {30'h0, s[1:0]});
      chk("carry", {31'h0, cnb}, {31'h0, s[2]});
    end
  endtask

  // slice 2 flops: flop0 from direct input, flop1 from table 1
  task automatic t_flop();
    chk("init", {30'h0, q[5:4]}, 32'h1);
    dir[4] <= 1'b0;
    ce[1] <= 1'b1;
    slk(1, 1'b1);
    chk("capture", {30'h0, q[5:4]}, 32'h2);
    rdc("status q", 32'h4, 32'h00007120);
    ce[1] <= 1'b0;
    dir[4] <= 1'b1;
    slk(1, 1'b0);
    slk(1, 1'b1);
    chk("ce hold", {30'h0, q[5:4]}, 32'h2);
    local_set_reset[1] <= 1'b1;
    slk(1, 1'b0);
    slk(1, 1'b1);
    chk("sync lsr", {30'h0, q[5:4]}, 32'h1);
    local_set_reset[1] <= 1'b0;
  endtask

  task automatic t_cmp_neg();
    logic [1:0] a;
    logic [1:0] b;
    wr(32'h0, 32'h0);
    wr(32'h20, 32'h00000780);
    wr(32'h28, 32'h00000032);
    wr(32'h0, 32'h00000001);
    for (int i = 0; i < 16; i++) begin
      a = 2'(i);
      b = 2'(i >> 2);
      @(posedge clk);
      ft[1:0] <= {b[0], a[0]};
      st[1:0] <= {b[1], a[1]};
      @(posedge clk);
      chk("ge", {31'h0, f0[0]}, {31'h0, a >= b});
      chk("ne", {31'h0, f1[0]}, {31'h0, a != b});
      chk("le", {31'h0, cnb}, {31'h0, a <= b});
    end
    dir[4] <= 1'b0;
    ce[1] <= 1'b1;
    slk(1, 1'b0);
    chk("fall capture", {30'h0, q[5:4]}, 32'h2);
    dir[4] <= 1'b1;
    slk(1, 1'b1);
    chk("rise ignored", {30'h0, q[5:4]}, 32'h2);
  endtask

  // lut5 merge, async set/reset, then a ram write through slice 2
  task automatic t_mem();
    wr(32'h0, 32'h0);
    wr(32'h10, 32'h0000FFFF);
    wr(32'h20, 32'h00000029);
    wr(32'h0, 32'h00000001);
    @(posedge clk);
    ft[3:0] <= 4'h0;
    st[3:0] <= 4'h8;
    @(posedge clk);
    chk("f0 lut4", {31'h0, f0[0]}, 32'h1);
    sel[0] <= 1'b1;
    @(posedge clk);
    chk("f0 lut5", {31'h0, f0[0]}, 32'h0);
    ce[0] <= 1'b1;
    slk(0, 1'b1);
    chk("q0 load", {30'h0, q[1:0]}, 32'h0);
    local_set_reset[0] <= 1'b1;
    repeat (2) @(posedge clk);
    chk("async lsr", {30'h0, q[1:0]}, 32'h1);
    local_set_reset[0] <= 1'b0;
    wr(32'h0, 32'h00000003);
    ft[11:8] <= 4'h5;
    st[11:8] <= 4'hA;
    dir[4] <= 1'b1;
    ce[1] <= 1'b1;
    slk(1, 1'b0);
    dir[4] <= 1'b0;
    chk("ram read", {28'h0, f1[1], f0[1], f1[0], f0[0]}, 32'hA);
    chk("ctl slice", {30'h0, f1[2], f0[2]}, 32'h0);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // watchdog: tests need a few hundred cycles
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_logic();
    t_add();
    t_flop();
    t_cmp_neg();
    t_mem();
    results();
  end
endmodule
`default_nettype wire
